/* src/rcc_cmd_handler.sv */
// Purpose: Card-side recording control command handler with APB registers
// Assumes: Command fields on pins are stable over a link clock period
// Notes: Media engine reports completion on be_done and faults on be_err
// Overview of operation
// - Start-recording busy lasts at most one second while preparing.
// - After update-directory, next single-block write fixes the directory location.
// - Directory area written by single blocks; repeats need no new function.
// - Every directory-area write counts as one of eight table cycles.
// - Update-directory during recording ends it; next write is new directory.
// - Update-directory busy is at most 10 ms.
// - Update-continuity during recording marks next single-block write as continuity.
// - Update-continuity busy is at most 10 ms.
// - Oversized directory or continuity write accepted, no error, performance lost.
// - Recording starts on start-recording, ends on update-directory or foreign write.
// - Grade reported in status: 0, 1 or 3; higher implies lower.
// - Reported allocation unit size never above 64 MB.
// - No grade claimed in two-lane half-duplex or low-power mode.
// - High-capacity grade cards perform without the recording control command.
// - Write busy at most 250 ms; extended-card directory write 500 ms.
// - Errors during command busy show in next command's status response.
// - Command answered by status response then function-dependent busy.
// - Command support shown by configuration register bit 32.
`timescale 1ns/10ps
module rcc_cmd_handler import rcc_pkg::*; #(
  parameter int START_CYC = START_BUSY_CYC,
  parameter int FN_CYC = FN_BUSY_CYC,
  parameter int WR_CYC = WR_BUSY_CYC,
  parameter int DIR_WR_CYC = DIR_WR_BUSY_CYC,
  parameter bit CMD_SUPPORT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_index,
  input wire logic [3:0] recording_function_select,
  input wire logic [31:0] cmd_addr,
  input wire logic [15:0] cmd_blocks,
  input wire logic be_done,
  input wire logic be_err,
  output logic busy,
  output logic resp_toggle,
  output logic resp_err,
  output logic rec_active,
  output logic [2:0] wr_class,
  output logic perf_ok
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (START_CYC < 1 || FN_CYC < 1 || WR_CYC < 1 || DIR_WR_CYC < 1) begin : g_chk
    $error("Busy bounds must be at least one cycle");
  end

  // ************************************************************
  // Link sampling
  // ************************************************************
  localparam int SW = 60;
  logic [SW-1:0] sync_q;
  logic lclk_s;
  logic lclk_prev_ff;
  logic take;
  logic [5:0] c_idx;
  logic [3:0] c_fn;
  logic [31:0] c_addr;
  logic [15:0] c_blk;

  rcc_sync #(.W(SW)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({link_clk, cmd_valid, cmd_index, recording_function_select, cmd_addr, cmd_blocks}),
    .q(sync_q)
  );

  assign lclk_s = sync_q[59];
  assign c_idx = sync_q[57:52];
  assign c_fn = sync_q[51:48];
  assign c_addr = sync_q[47:16];
  assign c_blk = sync_q[15:0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lclk_prev_ff <= 1'b0;
    end else begin
      lclk_prev_ff <= lclk_s;
    end
  end

  rcc_state_type state_ff;
  assign take = lclk_s && !lclk_prev_ff && sync_q[58] && (state_ff == ST_IDLE);

  // ************************************************************
  // Busy timer
  // ************************************************************
  rcc_busy_if bif ();

  rcc_busy_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .bif(bif)
  );

  // ************************************************************
  // Decode
  // ************************************************************
  logic [31:0] ctrl_ff;
  logic rec_ff;
  logic dir_pend_ff;
  logic ci_pend_ff;
  logic dir_valid_ff;
  logic dir_armed_ff;
  logic [31:0] dir_addr_ff;
  logic is_fn;
  logic is_wr;
  logic fn_bad;
  logic allowed;
  logic oversize;
  rcc_wclass_type wc;
  logic [31:0] cap;

  always_comb begin
    is_fn = (c_idx == CMD_REC_CTRL);
    is_wr = (c_idx == CMD_WR_SINGLE) || (c_idx == CMD_WR_MULTI);
    fn_bad = is_fn && (c_fn != FN_START_REC) && (c_fn != FN_UPDATE_DIR)
             && (c_fn != FN_UPDATE_CI);
    allowed = is_fn || is_wr || (c_idx == CMD_STATUS) || (c_idx == CMD_RD_SINGLE)
              || (c_idx == CMD_RD_MULTI) || (c_idx == CMD_ERASE_START)
              || (c_idx == CMD_ERASE_END) || (c_idx == CMD_ERASE)
              || (c_idx == CMD_SECURE);
    oversize = (c_blk > ONE_BLOCK);
    wc = WC_OTHER;
    if (dir_pend_ff || ci_pend_ff) begin
      wc = dir_pend_ff ? WC_DIR : WC_CI;
    end else if (dir_valid_ff && (c_addr == dir_addr_ff) && !oversize) begin
      wc = WC_DIR;
    end else if (rec_ff && ((c_blk & RU_MASK) == 16'h0000) && (c_blk != 16'h0000)) begin
      wc = WC_STREAM;
    end else if (rec_ff && (c_blk <= TABLE_MAX_BLOCKS)) begin
      wc = WC_TABLE;
    end
    cap = WR_CYC;
    if (is_fn) begin
      cap = (c_fn == FN_START_REC) ? START_CYC : FN_CYC;
    end else if (wc == WC_DIR && ctrl_ff[CTRL_EXT_CAP]) begin
      cap = DIR_WR_CYC;
    end
  end

  // ************************************************************
  // Command sequencing
  // ************************************************************
  logic [31:0] cap_ff;
  logic start_ff;
  logic busy_ff;
  logic resp_tg_ff;
  logic resp_err_ff;
  logic err_pend_ff;
  logic need_busy_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      start_ff <= 1'b0;
      busy_ff <= 1'b0;
      cap_ff <= 32'h0000_0001;
      need_busy_ff <= 1'b0;
      resp_tg_ff <= 1'b0;
      resp_err_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE: begin
          if (take) begin
            cap_ff <= cap;
            need_busy_ff <= (is_fn && !fn_bad) || is_wr;
            state_ff <= ST_RESP;
          end
        end
        ST_RESP: begin
          resp_tg_ff <= !resp_tg_ff;
          resp_err_ff <= err_pend_ff;
          if (need_busy_ff) begin
            start_ff <= 1'b1;
            busy_ff <= 1'b1;
            state_ff <= ST_BUSY;
          end else begin
            state_ff <= ST_IDLE;
          end
        end
        ST_BUSY: begin
          if (!start_ff && !bif.busy) begin
            busy_ff <= 1'b0;
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign bif.start = start_ff;
  assign bif.cap = cap_ff;
  assign bif.done = be_done;

  // Error caught during busy waits for the next response
  always_ff @(posedge clk) begin
    if (!nrst) begin
      err_pend_ff <= 1'b0;
    end else if ((busy_ff && be_err) || bif.expired || (take && fn_bad)) begin
      err_pend_ff <= 1'b1;
    end else if (state_ff == ST_RESP) begin
      err_pend_ff <= 1'b0;
    end
  end

  // ************************************************************
  // Recording state
  // ************************************************************
  logic [2:0] fat_idx_ff;
  logic [15:0] fat_total_ff;
  logic perf_lost_ff;
  logic [2:0] wclass_ff;
  logic pl_clr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rec_ff <= 1'b0;
      dir_pend_ff <= 1'b0;
      ci_pend_ff <= 1'b0;
      dir_armed_ff <= 1'b0;
    end else if (take) begin
      if (is_fn && c_fn == FN_START_REC) begin
        rec_ff <= 1'b1;
        dir_armed_ff <= 1'b0;
      end else if (is_fn && c_fn == FN_UPDATE_DIR) begin
        rec_ff <= 1'b0;
        dir_pend_ff <= 1'b1;
        ci_pend_ff <= 1'b0;
      end else if (is_fn && c_fn == FN_UPDATE_CI) begin
        ci_pend_ff <= rec_ff;
      end else if (is_wr) begin
        dir_pend_ff <= 1'b0;
        ci_pend_ff <= 1'b0;
        if (dir_pend_ff) begin
          dir_armed_ff <= 1'b1;
        end
        if (wc == WC_OTHER) begin
          rec_ff <= 1'b0;
        end
      end else if (!allowed) begin
        dir_armed_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_addr_ff <= 32'h0000_0000;
      dir_valid_ff <= 1'b0;
    end else if (take && is_wr && dir_pend_ff) begin
      dir_addr_ff <= c_addr;
      dir_valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fat_idx_ff <= 3'h0;
      fat_total_ff <= 16'h0000;
    end else if (take && is_wr && wc == WC_DIR) begin
      fat_idx_ff <= (fat_idx_ff == FAT_LAST_CYCLE) ? 3'h0 : fat_idx_ff + 3'h1;
      fat_total_ff <= fat_total_ff + 16'h0001;
    end
  end

  // Oversized write is taken silently; the set wins over a clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      perf_lost_ff <= 1'b0;
    end else if (take && is_wr && (dir_pend_ff || ci_pend_ff) && oversize) begin
      perf_lost_ff <= 1'b1;
    end else if (pl_clr) begin
      perf_lost_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wclass_ff <= WC_OTHER;
    end else if (take && is_wr) begin
      wclass_ff <= wc;
    end
  end

  // ************************************************************
  // Grade reporting
  // ************************************************************
  logic [3:0] grade_rep;
  logic perf_ok_ff;

  always_comb begin
    grade_rep = ctrl_ff[CTRL_GRADE_LSB +: 4];
    if (ctrl_ff[CTRL_HD_MODE] || ctrl_ff[CTRL_LP_MODE]) begin
      grade_rep = GRADE_0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      perf_ok_ff <= 1'b0;
    end else begin
      perf_ok_ff <= (grade_rep != GRADE_0) && !perf_lost_ff
                    && (rec_ff || !ctrl_ff[CTRL_EXT_CAP]);
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic wr_ok;
  logic mapped;
  logic [3:0] g_in;
  logic [3:0] au_in;
  logic [31:0] rd_val;

  assign wr_ok = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign pl_clr = wr_ok && (paddr == OFS_STATUS) && pwdata[ST_PERF_LOST];

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: rd_val = ctrl_ff;
      OFS_STATUS: rd_val = {22'h000000, grade_rep, err_pend_ff, perf_lost_ff,
                            dir_armed_ff, ci_pend_ff, dir_pend_ff, rec_ff};
      OFS_DIR_ADDR: rd_val = dir_addr_ff;
      OFS_FAT_CNT: rd_val = {13'h0000, fat_total_ff, fat_idx_ff};
      OFS_CFG_HI: rd_val = {31'h00000000, CMD_SUPPORT};
      default: mapped = 1'b0;
    endcase
    g_in = pwdata[CTRL_GRADE_LSB +: 4];
    if (g_in == GRADE_2) begin
      g_in = GRADE_1;
    end else if (g_in > GRADE_3) begin
      g_in = GRADE_3;
    end
    au_in = pwdata[CTRL_AU_LSB +: 4];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !mapped;
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_ok && paddr == OFS_CTRL) begin
      ctrl_ff <= {21'h000000, pwdata[CTRL_LP_MODE], pwdata[CTRL_HD_MODE],
                  pwdata[CTRL_EXT_CAP], au_in, g_in};
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign busy = busy_ff;
  assign resp_toggle = resp_tg_ff;
  assign resp_err = resp_err_ff;
  assign rec_active = rec_ff;
  assign wr_class = wclass_ff;
  assign perf_ok = perf_ok_ff;

endmodule : rcc_cmd_handler

/* src/rcc_pkg.sv */
// Purpose: Shared constants and types of the recording control command handler
// Assumes: 100 MHz core clock, 512-byte blocks
// Notes: APB offsets are byte addresses of aligned 32-bit words
package rcc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_KHZ = 100000;
  localparam int START_BUSY_MS = 1000;
  localparam int FN_BUSY_MS = 10;
  localparam int WR_BUSY_MS = 250;
  localparam int DIR_WR_BUSY_MS = 500;
  localparam int START_BUSY_CYC = START_BUSY_MS * CLK_KHZ;
  localparam int FN_BUSY_CYC = FN_BUSY_MS * CLK_KHZ;
  localparam int WR_BUSY_CYC = WR_BUSY_MS * CLK_KHZ;
  localparam int DIR_WR_BUSY_CYC = DIR_WR_BUSY_MS * CLK_KHZ;

  // ************************************************************
  // Commands and functions
  // ************************************************************
  localparam logic [5:0] CMD_STATUS = 6'h0d;
  localparam logic [5:0] CMD_RD_SINGLE = 6'h11;
  localparam logic [5:0] CMD_RD_MULTI = 6'h12;
  localparam logic [5:0] CMD_REC_CTRL = 6'h14;
  localparam logic [5:0] CMD_WR_SINGLE = 6'h18;
  localparam logic [5:0] CMD_WR_MULTI = 6'h19;
  localparam logic [5:0] CMD_ERASE_START = 6'h20;
  localparam logic [5:0] CMD_ERASE_END = 6'h21;
  localparam logic [5:0] CMD_ERASE = 6'h26;
  localparam logic [5:0] CMD_SECURE = 6'h2a;
  localparam logic [3:0] FN_START_REC = 4'h0;
  localparam logic [3:0] FN_UPDATE_DIR = 4'h1;
  localparam logic [3:0] FN_UPDATE_CI = 4'h2;

  // ************************************************************
  // Write sizes in blocks and last table cycle index
  // ************************************************************
  localparam logic [15:0] ONE_BLOCK = 16'h0001;
  localparam logic [15:0] RU_MASK = 16'h03ff;
  localparam logic [15:0] TABLE_MAX_BLOCKS = 16'h0020;
  localparam logic [2:0] FAT_LAST_CYCLE = 3'h7;

  // ************************************************************
  // Grades and allocation unit size code
  // ************************************************************
  localparam logic [3:0] GRADE_0 = 4'h0;
  localparam logic [3:0] GRADE_1 = 4'h1;
  localparam logic [3:0] GRADE_2 = 4'h2;
  localparam logic [3:0] GRADE_3 = 4'h3;
  localparam logic [3:0] AU_SIZE_64MB_CODE = 4'hf;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DIR_ADDR = 12'h008;
  localparam logic [11:0] OFS_FAT_CNT = 12'h00c;
  localparam logic [11:0] OFS_CFG_HI = 12'h014;
  localparam int CTRL_GRADE_LSB = 0;
  localparam int CTRL_AU_LSB = 4;
  localparam int CTRL_EXT_CAP = 8;
  localparam int CTRL_HD_MODE = 9;
  localparam int CTRL_LP_MODE = 10;
  localparam int ST_PERF_LOST = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RESP = 3'b010,
    ST_BUSY = 3'b100
  } rcc_state_type;

  typedef enum logic [2:0] {
    WC_OTHER = 3'h0,
    WC_STREAM = 3'h1,
    WC_TABLE = 3'h2,
    WC_DIR = 3'h3,
    WC_CI = 3'h4
  } rcc_wclass_type;

endpackage : rcc_pkg

/* src/rcc_busy_if.sv */
// Purpose: Carrier between the command handler and its busy timer
// Assumes: All signals on the core clock
// Notes: None
`timescale 1ns/10ps
interface rcc_busy_if;
  logic start;
  logic [31:0] cap;
  logic done;
  logic busy;
  logic expired;
  modport timer (input start, input cap, input done, output busy, output expired);
  modport ctrl (output start, output cap, output done, input busy, input expired);
endinterface : rcc_busy_if

/* src/rcc_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of pins
// Assumes: Bundle changes slowly against the core clock
// Notes: Only the second stage is visible
`timescale 1ns/10ps
module rcc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : rcc_sync

/* src/rcc_busy_timer.sv */
// Purpose: Busy period with an upper bound in cycles
// Assumes: cap of at least one cycle
// Notes: Ends early on done, flags expiry when the bound is hit
`timescale 1ns/10ps
module rcc_busy_timer (
  input wire logic clk,
  input wire logic nrst,
  rcc_busy_if.timer bif
);
  logic [31:0] cnt_ff;
  logic busy_ff;
  logic expired_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= 32'h0000_0000;
      busy_ff <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= 1'b0;
      if (bif.start) begin
        cnt_ff <= bif.cap - 32'h0000_0001;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (bif.done) begin
          busy_ff <= 1'b0;
        end else if (cnt_ff == 32'h0000_0000) begin
          busy_ff <= 1'b0;
          expired_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 32'h0000_0001;
        end
      end
    end
  end

  assign bif.busy = busy_ff;
  assign bif.expired = expired_ff;
endmodule : rcc_busy_timer

/* dv/rcc_cmd_handler_assertions.sv */
// Purpose: Port checks of the recording control command handler
// Assumes: Command fields held while the response toggles
// Notes: Bound to the top module
`timescale 1ns/10ps
module rcc_cmd_handler_assertions import rcc_pkg::*; #(
  parameter int START_CYC = START_BUSY_CYC,
  parameter int FN_CYC = FN_BUSY_CYC,
  parameter int DIR_WR_CYC = DIR_WR_BUSY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] cmd_index,
  input wire logic [3:0] recording_function_select,
  input wire logic [15:0] cmd_blocks,
  input wire logic be_done,
  input wire logic busy,
  input wire logic resp_toggle,
  input wire logic resp_err,
  input wire logic rec_active,
  input wire logic [2:0] wr_class
);
  // ************************************************************
  // Response tracking
  // ************************************************************
  logic tog_ff;
  logic [1:0] kind_ff;
  logic [31:0] cnt_ff;
  logic rsp;
  logic ctl;
  assign rsp = resp_toggle != tog_ff;
  assign ctl = rsp && cmd_index == CMD_REC_CTRL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk) begin
    tog_ff <= nrst && resp_toggle;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      kind_ff <= 2'h0;
    end else if (ctl) begin
      kind_ff <= (recording_function_select == FN_START_REC) ? 2'h1 : 2'h2;
    end else if (rsp) begin
      kind_ff <= 2'h3;
    end
  end
  always_ff @(posedge clk) begin
    cnt_ff <= (nrst && busy) ? cnt_ff + 32'h1 : 32'h0;
  end
  sequence fn_s(logic [3:0] f);
    ctl && recording_function_select == f;
  endsequence
  sequence done_s;
    busy && be_done;
  endsequence
  start_busy_cap_a: assert property (kind_ff == 2'h1 |-> cnt_ff <= START_CYC + 2)
    else $error("start busy too long");
  fn_busy_cap_a: assert property (kind_ff == 2'h2 |-> cnt_ff <= FN_CYC + 2)
    else $error("function busy too long");
  wr_busy_cap_a: assert property (kind_ff == 2'h3 |-> cnt_ff <= DIR_WR_CYC + 2)
    else $error("write busy too long");
  ctrl_busy_a: assert property (ctl && recording_function_select <= 4'h2 |-> busy)
    else $error("no busy after control response");
  bad_fn_a: assert property (fn_s(4'h3) |-> resp_err && !busy)
    else $error("bad function not refused");
  start_rec_a: assert property (fn_s(FN_START_REC) |-> rec_active)
    else $error("recording not started");
  dir_ends_rec_a: assert property (fn_s(FN_UPDATE_DIR) |-> !rec_active)
    else $error("recording not ended");
  done_ends_busy_a: assert property (done_s |-> ##[1:2] !busy)
    else $error("busy stuck after done");
  stream_class_a: assert property (rsp && rec_active && cmd_index == CMD_WR_MULTI &&
    cmd_blocks == RU_MASK + 16'h1 |-> wr_class == WC_STREAM)
    else $error("stream write misclassed");
endmodule : rcc_cmd_handler_assertions

bind rcc_cmd_handler rcc_cmd_handler_assertions #(.START_CYC(START_CYC), .FN_CYC(FN_CYC),
  .DIR_WR_CYC(DIR_WR_CYC)) u_chk (.clk(clk), .nrst(nrst), .cmd_index(cmd_index),
  .recording_function_select(recording_function_select), .cmd_blocks(cmd_blocks),
  .be_done(be_done), .busy(busy), .resp_toggle(resp_toggle), .resp_err(resp_err),
  .rec_active(rec_active), .wr_class(wr_class));

/* dv/rcc_host_model.sv */
// Purpose: Host controller model sending commands on the card bus
// Assumes: Link clock of 160 ns, still between frames
// Notes: Released fields show the inverse of their last value
`timescale 1ns/10ps
module rcc_host_model (
  output logic link_clk,
  output logic cmd_valid,
  output logic [5:0] cmd_index,
  output logic [3:0] recording_function_select,
  output logic [31:0] cmd_addr,
  output logic [15:0] cmd_blocks
);
  initial begin
    link_clk = 1'b0;
    cmd_valid = 1'b0;
    cmd_index = 6'h00;
    recording_function_select = 4'h0;
    cmd_addr = 32'h0;
    cmd_blocks = 16'h0;
  end
  // One frame: fields, one link clock rise, then release
  task automatic send(input logic [5:0] i, input logic [3:0] f, input logic [31:0] a,
                      input logic [15:0] b);
    #3;
    cmd_index = i;
    recording_function_select = f;
    cmd_addr = a;
    cmd_blocks = b;
    cmd_valid = 1'b1;
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
    #80 cmd_valid = 1'b0;
    cmd_index = ~i;
    recording_function_select = ~f;
    cmd_addr = ~a;
    cmd_blocks = ~b;
  endtask : send
endmodule : rcc_host_model

/* dv/recording_control_cmd_handler_bench.sv */
// Purpose: Self-checking bench of the recording control command handler
// Assumes: Shortened busy caps
// Notes: Command rows in a table, register and reset cases by hand
`timescale 1ns/10ps
module recording_control_cmd_handler_bench import rcc_pkg::*; ();
  typedef struct packed {
    logic [5:0] idx;
    logic [3:0] fn;
    logic [31:0] adr;
    logic [15:0] blk;
    logic [1:0] fault;
    logic rec;
    logic [2:0] cls;
    logic err;
  } rcc_row_type;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic be_done = 1'b0;
  logic be_err = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, link_clk, cmd_valid, busy, resp_toggle, resp_err, rec_active, perf_ok;
  logic [5:0] cmd_index;
  logic [3:0] fsel;
  logic [31:0] cmd_addr;
  logic [15:0] cmd_blocks;
  logic [2:0] wr_class;
  logic [31:0] d;
  logic e;
  int err_count = 0;
  int checks = 0;
  rcc_row_type rows [20] = '{
    '{6'h14, 4'h1, 32'h0, 16'h0, 2'h0, 1'b0, 3'h7, 1'b0},
    '{6'h18, 4'h0, 32'h100, 16'h1, 2'h0, 1'b0, 3'h3, 1'b0},
    '{6'h14, 4'h0, 32'h0, 16'h0, 2'h0, 1'b1, 3'h7, 1'b0},
    '{6'h19, 4'h0, 32'h1000, 16'h400, 2'h0, 1'b1, 3'h1, 1'b0},
    '{6'h19, 4'h0, 32'h3000, 16'h20, 2'h0, 1'b1, 3'h2, 1'b0},
    '{6'h18, 4'h0, 32'h100, 16'h1, 2'h0, 1'b1, 3'h3, 1'b0},
    '{6'h14, 4'h2, 32'h0, 16'h0, 2'h0, 1'b1, 3'h7, 1'b0},
    '{6'h18, 4'h0, 32'h2000, 16'h1, 2'h0, 1'b1, 3'h4, 1'b0},
    '{6'h14, 4'h2, 32'h0, 16'h0, 2'h1, 1'b1, 3'h7, 1'b0},
    '{6'h0d, 4'h0, 32'h0, 16'h0, 2'h0, 1'b1, 3'h7, 1'b1},
    '{6'h14, 4'h2, 32'h0, 16'h0, 2'h0, 1'b1, 3'h7, 1'b0},
    '{6'h19, 4'h0, 32'h2200, 16'h3, 2'h0, 1'b1, 3'h7, 1'b0},
    '{6'h19, 4'h0, 32'h4000, 16'h400, 2'h2, 1'b1, 3'h1, 1'b0},
    '{6'h0d, 4'h0, 32'h0, 16'h0, 2'h0, 1'b1, 3'h7, 1'b1},
    '{6'h14, 4'h1, 32'h0, 16'h0, 2'h0, 1'b0, 3'h7, 1'b0},
    '{6'h18, 4'h0, 32'h300, 16'h1, 2'h0, 1'b0, 3'h3, 1'b0},
    '{6'h11, 4'h0, 32'h300, 16'h1, 2'h0, 1'b0, 3'h7, 1'b0},
    '{6'h14, 4'h3, 32'h0, 16'h0, 2'h0, 1'b0, 3'h7, 1'b1},
    '{6'h14, 4'h0, 32'h0, 16'h0, 2'h0, 1'b1, 3'h7, 1'b0},
    '{6'h19, 4'h0, 32'h5000, 16'h41, 2'h0, 1'b0, 3'h0, 1'b0}};
  always #5 clk = ~clk;
  rcc_host_model host (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .recording_function_select(fsel), .cmd_addr(cmd_addr), .cmd_blocks(cmd_blocks));
  rcc_cmd_handler #(.START_CYC(50), .FN_CYC(20), .WR_CYC(30), .DIR_WR_CYC(40)) dut (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_index(cmd_index), .recording_function_select(fsel),
    .cmd_addr(cmd_addr), .cmd_blocks(cmd_blocks), .be_done(be_done), .be_err(be_err),
    .busy(busy), .resp_toggle(resp_toggle), .resp_err(resp_err), .rec_active(rec_active),
    .wr_class(wr_class), .perf_ok(perf_ok));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
                        input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, x, d & m);
  endtask : rd_chk
  task automatic run_row(input rcc_row_type w);
    logic t;
    t = resp_toggle;
    host.send(w.idx, w.fn, w.adr, w.blk);
    @(negedge clk);
    while (resp_toggle === t) @(negedge clk);
    chk("resp_err", {31'h0, w.err}, {31'h0, resp_err});
    if (busy === 1'b1 && w.fault != 2'h1) begin
      @(posedge clk);
      be_err <= w.fault[1];
      @(posedge clk);
      be_err <= 1'b0;
      be_done <= 1'b1;
    end
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
    @(posedge clk);
    be_done <= 1'b0;
    chk("rec_active", {31'h0, w.rec}, {31'h0, rec_active});
    if (w.cls != 3'h7) chk("wr_class", {29'h0, w.cls}, {29'h0, wr_class});
  endtask : run_row
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFS_CTRL, 32'hffffffff, CTRL_RESET, "ctrl_reset");
    apb(1'b1, OFS_CTRL, 32'h0000_00f2);
    rd_chk(OFS_CTRL, 32'h0000_07ff, 32'h0000_00f1, "grade_two");
    apb(1'b1, OFS_CTRL, 32'h0000_0405);
    rd_chk(OFS_CTRL, 32'h0000_07ff, 32'h0000_0403, "grade_clamp");
    rd_chk(OFS_STATUS, 32'h0000_03c0, 32'h0, "grade_low_power");
    apb(1'b1, OFS_CTRL, 32'h0000_0203);
    rd_chk(OFS_STATUS, 32'h0000_03c0, 32'h0, "grade_half_duplex");
    apb(1'b1, OFS_CTRL, 32'h0000_0003);
    rd_chk(OFS_STATUS, 32'h0000_03c0, 32'h0000_00c0, "grade_three");
    chk("perf_ok", 32'h1, {31'h0, perf_ok});
    rd_chk(OFS_CFG_HI, 32'h1, 32'h1, "cmd_support");
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    for (int r = 0; r < 20; r++) begin
      run_row(rows[r]);
    end
    rd_chk(OFS_DIR_ADDR, 32'hffffffff, 32'h300, "dir_addr");
    rd_chk(OFS_FAT_CNT, 32'h0007_ffff, 32'h1b, "table_cycles");
    rd_chk(OFS_STATUS, 32'h10, 32'h10, "perf_lost");
    apb(1'b1, OFS_STATUS, 32'h10);
    rd_chk(OFS_STATUS, 32'h10, 32'h0, "perf_clear");
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFS_CTRL, 32'hffffffff, CTRL_RESET, "ctrl_rereset");
    chk("rec_rereset", 32'h0, {31'h0, rec_active});
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule : recording_control_cmd_handler_bench
